// [core/lsd_pkg.sv]
// Overview of operation
// - scanning runs only while the scan-on bit (bit 7) is set; stops when clear
// - bit 6 selects waveform style: 0 liquid-crystal, 1 LED multiplex
// - one display type at a time; both share the same lines and registers
// - duty 00: eight commons on lines 0-7, segments on lines 8-27, 1/8 each
// - duty 01: six commons on lines 2-7, segments on lines 0-1 and 8-27, 1/6 each
// - duty 10: five commons on lines 3-7, segments on lines 0-2 and 8-27, 1/5 each
// - duty 11: four commons on lines 4-7 or 0-3, segments on the rest
// - four-common mode: swap bit 0 puts commons on 4-7, 1 on 0-3
// - scan timing from internal 32 kHz RC or external 32.768 kHz crystal
// - low-frequency clock divided so one full frame repeats near 64 Hz
// - LCD mode makes waveforms for 1/4 or 1/3 bias as configured
// - port-0 pin n carries display output only while its enable bit is 1
// - port-1 pin n carries display output only while its enable bit is 1
// - port-2 pin n carries display output only while its enable bit is 1
//
package lsd_pkg;

   // ----------------------------------------------------------------
   // bus and sizes
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int NUM_LINES = 28;
   localparam int NUM_PORT_PINS = 24;
   localparam int LVL_W = 3;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_OUT_CTRL = 16'h008f;
   localparam logic [ADDR_W-1:0] OFS_DRV_CTRL = 16'h0093;
   localparam logic [ADDR_W-1:0] OFS_P1_VO = 16'h0094;
   localparam logic [ADDR_W-1:0] OFS_P0_VO = 16'h009c;
   localparam logic [ADDR_W-1:0] OFS_P2_VO = 16'h00a3;
   localparam logic [ADDR_W-1:0] OFS_CLK_SEL = 16'h00a4;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 16'h00a5;
   localparam logic [ADDR_W-1:0] OFS_RAM_BASE = 16'h2000;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int BIT_SCAN_ON = 7;
   localparam int BIT_LED_MODE = 6;
   localparam int DUTY_LSB = 4;
   localparam int TRIM_LSB = 0;
   localparam int BIT_SWAP = 1;
   localparam int BIT_BIAS = 0;
   localparam int BIT_CLK_XTAL = 0;
   localparam logic [DATA_W-1:0] RST_REG = 8'h00;

   // ----------------------------------------------------------------
   // frame timing: low-frequency edges per frame
   // ----------------------------------------------------------------
   localparam int LF_HZ = 32768;
   localparam int FRAME_HZ = 64;
   localparam int FRAME_TICKS = LF_HZ / FRAME_HZ;
   localparam int TICK_W = 9;

   // ----------------------------------------------------------------
   // drive levels (in steps of the bias divider)
   // ----------------------------------------------------------------
   localparam logic [LVL_W-1:0] LVL_GND = 3'h0;
   localparam logic [LVL_W-1:0] LVL_ONE = 3'h1;
   localparam logic [LVL_W-1:0] LVL_TWO = 3'h2;
   localparam logic [LVL_W-1:0] LVL_TOP3 = 3'h3;
   localparam logic [LVL_W-1:0] LVL_TOP4 = 3'h4;

   typedef enum logic [1:0] {DUTY_8, DUTY_6, DUTY_5, DUTY_4} lsd_duty_e;

   typedef struct packed {
      logic scan_on;
      logic led_mode;
      lsd_duty_e duty;
      logic [3:0] trim;
      logic swap;
      logic bias_third;
      logic clk_xtal;
   } lsd_cfg_s;

   // number of commons for a duty code
   function automatic logic [3:0] com_count(input lsd_duty_e d);
      case (d)
         DUTY_8: com_count = 4'h8;
         DUTY_6: com_count = 4'h6;
         DUTY_5: com_count = 4'h5;
         default: com_count = 4'h4;
      endcase
   endfunction : com_count

   // first line used as a common
   function automatic logic [4:0] com_first(input lsd_duty_e d, input logic swap);
      case (d)
         DUTY_8: com_first = 5'h00;
         DUTY_6: com_first = 5'h02;
         DUTY_5: com_first = 5'h03;
         default: com_first = swap ? 5'h00 : 5'h04;
      endcase
   endfunction : com_first

   // low-frequency edges spent on each common
   function automatic logic [TICK_W-1:0] ticks_per_com(input lsd_duty_e d);
      ticks_per_com = TICK_W'(FRAME_TICKS / int'(com_count(d)));
   endfunction : ticks_per_com

endpackage : lsd_pkg

// [core/lsd_scan_timer.sv]
`timescale 1ns/100ps
module lsd_scan_timer
   import lsd_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // low-frequency clock pins
   input wire logic rc_osc_pin,
   input wire logic xtal_pin,
   // configuration
   input wire logic run,
   input wire logic clk_xtal,
   input wire lsd_pkg::lsd_duty_e duty,
   // scan position
   output logic [2:0] com_idx,
   output logic frame_flip
);
   import lsd_pkg::*;

   logic [1:0] rc_sync_q;
   logic [1:0] xtal_sync_q;
   logic src_prev_q;
   logic src_now;
   logic src_rise;
   logic [TICK_W-1:0] tick_q;
   logic [2:0] com_q;
   logic flip_q;
   logic [3:0] ncom;

   // ----------------------------------------------------------------
   // synchronisers for both low-frequency sources
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rc_sync_q <= 2'h0;
         xtal_sync_q <= 2'h0;
      end else begin
         rc_sync_q <= {rc_sync_q[0], rc_osc_pin};
         xtal_sync_q <= {xtal_sync_q[0], xtal_pin};
      end
   end

   // source select and rising edge detect on synchronised level
   assign src_now = clk_xtal ? xtal_sync_q[1] : rc_sync_q[1];
   assign src_rise = src_now & ~src_prev_q;
   assign ncom = com_count(duty);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         src_prev_q <= 1'b0;
      end else begin
         src_prev_q <= src_now;
      end
   end

   // tick divider, common stepping and frame polarity
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tick_q <= '0;
         com_q <= 3'h0;
         flip_q <= 1'b0;
      end else if (!run) begin
         tick_q <= '0;
         com_q <= 3'h0;
         flip_q <= 1'b0;
      end else if ({1'b0, com_q} >= ncom) begin
         com_q <= 3'h0; // duty shrank mid-frame
         tick_q <= '0;
      end else if (src_rise) begin
         if (tick_q >= ticks_per_com(duty) - 9'h001) begin
            tick_q <= '0;
            if ({1'b0, com_q} == ncom - 4'h1) begin
               com_q <= 3'h0;
               flip_q <= ~flip_q;
            end else begin
               com_q <= com_q + 3'h1;
            end
         end else begin
            tick_q <= tick_q + 9'h001;
         end
      end
   end

   assign com_idx = com_q;
   assign frame_flip = flip_q;

endmodule : lsd_scan_timer

// [core/lsd_display_driver.sv]
// Strobed register access is this design's own decision.
`timescale 1ns/100ps
module lsd_display_driver
   import lsd_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // register port
   input wire logic [lsd_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [lsd_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [lsd_pkg::DATA_W-1:0] REG_RDATA,
   // low-frequency clock pins
   input wire logic LOW_FREQ_RC_OSCILLATOR,
   input wire logic XTAL_CLK_PIN,
   // display lines
   output logic [lsd_pkg::NUM_LINES-1:0][lsd_pkg::LVL_W-1:0] LINE_LEVEL,
   output logic [lsd_pkg::NUM_LINES-1:0] LINE_OE,
   output logic [lsd_pkg::NUM_LINES-1:0] LINE_IS_COM,
   // analog controls
   output logic [3:0] LCD_VOLTAGE_TRIM,
   output logic BIAS_THIRD,
   output logic LED_MODE,
   output logic SCAN_ACTIVE
);
   import lsd_pkg::*;

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] drv_ctrl_q;
   logic [DATA_W-1:0] out_ctrl_q;
   logic [DATA_W-1:0] port0_vo_q;
   logic [DATA_W-1:0] port1_vo_q;
   logic [DATA_W-1:0] port2_vo_q;
   logic [DATA_W-1:0] clk_sel_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] disp_ram [NUM_LINES];

   lsd_cfg_s cfg;
   logic [2:0] com_idx;
   logic frame_flip;
   logic [4:0] first_com;
   logic [3:0] ncom;
   logic [4:0] act_line;
   logic ram_hit;
   logic [4:0] ram_idx;
   logic [ADDR_W-1:0] ram_ofs;

   logic [NUM_LINES-1:0][LVL_W-1:0] level_d;
   logic [NUM_LINES-1:0][LVL_W-1:0] level_q;
   logic [NUM_LINES-1:0] is_com_d;
   logic [NUM_LINES-1:0] is_com_q;
   logic [NUM_LINES-1:0] oe_q;

   // ----------------------------------------------------------------
   // configuration decode
   // ----------------------------------------------------------------
   // both display types share one set of control fields
   assign cfg.scan_on = drv_ctrl_q[BIT_SCAN_ON];
   assign cfg.led_mode = drv_ctrl_q[BIT_LED_MODE];
   assign cfg.duty = lsd_duty_e'(drv_ctrl_q[DUTY_LSB +: 2]);
   assign cfg.trim = drv_ctrl_q[TRIM_LSB +: 4];
   assign cfg.swap = out_ctrl_q[BIT_SWAP];
   assign cfg.bias_third = out_ctrl_q[BIT_BIAS];
   assign cfg.clk_xtal = clk_sel_q[BIT_CLK_XTAL];

   assign first_com = com_first(cfg.duty, cfg.swap);
   assign ncom = com_count(cfg.duty);
   assign act_line = first_com + {2'h0, com_idx};

   // display memory window decode
   assign ram_ofs = REG_ADDR - OFS_RAM_BASE;
   assign ram_hit = (REG_ADDR >= OFS_RAM_BASE)
                    && (ram_ofs < ADDR_W'(NUM_LINES));
   assign ram_idx = ram_ofs[4:0];

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         drv_ctrl_q <= RST_REG;
         out_ctrl_q <= RST_REG;
         clk_sel_q <= RST_REG;
      end else if (REG_WR) begin
         case (REG_ADDR)
            OFS_DRV_CTRL: drv_ctrl_q <= REG_WDATA;
            OFS_OUT_CTRL: out_ctrl_q <= REG_WDATA;
            OFS_CLK_SEL: clk_sel_q <= {7'h00, REG_WDATA[BIT_CLK_XTAL]};
            default: ;
         endcase
      end
   end

   // port display-output enables
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         port0_vo_q <= RST_REG;
         port1_vo_q <= RST_REG;
         port2_vo_q <= RST_REG;
      end else if (REG_WR) begin
         case (REG_ADDR)
            OFS_P0_VO: port0_vo_q <= REG_WDATA;
            OFS_P1_VO: port1_vo_q <= REG_WDATA;
            OFS_P2_VO: port2_vo_q <= REG_WDATA;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // display memory: one byte per line, bit n = common line n
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (REG_WR && ram_hit) begin
         disp_ram[ram_idx] <= REG_WDATA;
      end
   end

   // ----------------------------------------------------------------
   // read path: data stands one cycle after the strobe only
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      if (REG_RD) begin
         if (ram_hit) begin
            rdata_d = disp_ram[ram_idx];
         end else begin
            case (REG_ADDR)
               OFS_DRV_CTRL: rdata_d = drv_ctrl_q;
               OFS_OUT_CTRL: rdata_d = out_ctrl_q;
               OFS_P0_VO: rdata_d = port0_vo_q;
               OFS_P1_VO: rdata_d = port1_vo_q;
               OFS_P2_VO: rdata_d = port2_vo_q;
               OFS_CLK_SEL: rdata_d = clk_sel_q;
               OFS_STATUS: rdata_d = {cfg.scan_on, 3'h0, frame_flip, com_idx};
               default: rdata_d = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // scan timing
   // ----------------------------------------------------------------
   lsd_scan_timer u_timer (
      .clk(REF_CLK),
      .nrst(NRST),
      .rc_osc_pin(LOW_FREQ_RC_OSCILLATOR),
      .xtal_pin(XTAL_CLK_PIN),
      .run(cfg.scan_on),
      .clk_xtal(cfg.clk_xtal),
      .duty(cfg.duty),
      .com_idx(com_idx),
      .frame_flip(frame_flip)
   );

   // ----------------------------------------------------------------
   // waveform generation per line
   // ----------------------------------------------------------------
   // lcd: selected common at top, others one step in; inverted on odd
   // frames so the glass sees no net dc
   always_comb begin
      logic [LVL_W-1:0] top;
      logic [4:0] ln;
      logic seg_on;
      top = cfg.bias_third ? LVL_TOP3 : LVL_TOP4;
      ln = 5'h00;
      seg_on = 1'b0;
      level_d = '0;
      is_com_d = '0;
      for (int i = 0; i < NUM_LINES; i++) begin
         ln = 5'(i);
         // common band per duty while scanning, segments elsewhere
         is_com_d[i] = cfg.scan_on && (ln >= first_com)
                       && ({1'b0, ln} < {1'b0, first_com} + {2'h0, ncom});
         seg_on = disp_ram[i][act_line[2:0]];
         if (!cfg.scan_on) begin
            level_d[i] = LVL_GND;
         end else if (cfg.led_mode) begin
            // led: plain high/low multiplex
            if (is_com_d[i]) begin
               level_d[i] = (ln == act_line) ? top : LVL_GND;
            end else begin
               level_d[i] = seg_on ? top : LVL_GND;
            end
         end else if (is_com_d[i]) begin
            if (ln == act_line) begin
               level_d[i] = frame_flip ? LVL_GND : top;
            end else begin
               level_d[i] = frame_flip ? top - LVL_ONE : LVL_ONE;
            end
         end else begin
            if (seg_on) begin
               level_d[i] = frame_flip ? top : LVL_GND;
            end else if (cfg.bias_third) begin
               level_d[i] = frame_flip ? LVL_ONE : LVL_TWO;
            end else begin
               level_d[i] = LVL_TWO;
            end
         end
      end
   end

   // registered line levels and common map
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         level_q <= '0;
         is_com_q <= '0;
      end else begin
         level_q <= level_d;
         is_com_q <= is_com_d;
      end
   end

   // ----------------------------------------------------------------
   // pin routing: lines 0-23 follow ports 0-2, the rest follow scan-on
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         oe_q <= '0;
      end else begin
         oe_q[7:0] <= port0_vo_q;
         oe_q[15:8] <= port1_vo_q;
         oe_q[23:16] <= port2_vo_q;
         oe_q[NUM_LINES-1:NUM_PORT_PINS] <= {4{cfg.scan_on}};
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign REG_RDATA = rdata_q;
   assign LINE_LEVEL = level_q;
   assign LINE_OE = oe_q;
   assign LINE_IS_COM = is_com_q;
   assign LCD_VOLTAGE_TRIM = cfg.trim;
   assign BIAS_THIRD = out_ctrl_q[BIT_BIAS];
   assign LED_MODE = drv_ctrl_q[BIT_LED_MODE];
   assign SCAN_ACTIVE = drv_ctrl_q[BIT_SCAN_ON];

endmodule : lsd_display_driver

// [verif/lsd_checker.sv]
`timescale 1ns/100ps
module lsd_checker
   import lsd_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // register port
   input wire logic [lsd_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [lsd_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WR,
   // display lines and controls
   input wire logic [lsd_pkg::NUM_LINES-1:0][lsd_pkg::LVL_W-1:0] LINE_LEVEL,
   input wire logic [lsd_pkg::NUM_LINES-1:0] LINE_OE,
   input wire logic [lsd_pkg::NUM_LINES-1:0] LINE_IS_COM,
   input wire logic [3:0] LCD_VOLTAGE_TRIM,
   input wire logic BIAS_THIRD,
   input wire logic LED_MODE,
   input wire logic SCAN_ACTIVE
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!NRST);
   logic any_mid;
   logic any_four;
   // ----
   // level classes over all lines
   // ----
   always_comb begin
      any_mid = 1'b0;
      any_four = 1'b0;
      for (int i = 0; i < NUM_LINES; i++) begin
         any_mid |= LINE_LEVEL[i] inside {LVL_ONE, LVL_TWO};
         any_four |= LINE_LEVEL[i] == LVL_TOP4;
      end
   end
   // ----
   // assertions
   // ----
   a_scan_off_idle:
   assert property (!SCAN_ACTIVE [*3] |-> LINE_LEVEL == '0 && LINE_IS_COM == '0)
      else $error("lines busy while scan is off");
   a_ctrl_fields:
   assert property (REG_WR && REG_ADDR == OFS_DRV_CTRL |=> {SCAN_ACTIVE, LED_MODE,
      LCD_VOLTAGE_TRIM} == {$past(REG_WDATA[7:6]), $past(REG_WDATA[3:0])})
      else $error("control fields not taken");
   a_bias_pass:
   assert property (REG_WR && REG_ADDR == OFS_OUT_CTRL |=> BIAS_THIRD == $past(REG_WDATA[0]))
      else $error("bias select not taken");
   a_port0_oe:
   assert property (REG_WR && REG_ADDR == OFS_P0_VO ##1 !(REG_WR && REG_ADDR == OFS_P0_VO)
      |=> LINE_OE[7:0] == $past(REG_WDATA, 2)) else $error("port0 enables wrong");
   a_port1_oe:
   assert property (REG_WR && REG_ADDR == OFS_P1_VO ##1 !(REG_WR && REG_ADDR == OFS_P1_VO)
      |=> LINE_OE[15:8] == $past(REG_WDATA, 2)) else $error("port1 enables wrong");
   a_port2_oe:
   assert property (REG_WR && REG_ADDR == OFS_P2_VO ##1 !(REG_WR && REG_ADDR == OFS_P2_VO)
      |=> LINE_OE[23:16] == $past(REG_WDATA, 2)) else $error("port2 enables wrong");
   a_com_band:
   assert property (LINE_IS_COM[27:8] == '0 &&
      LINE_IS_COM[7:0] inside {8'h00, 8'hff, 8'hfc, 8'hf8, 8'hf0, 8'h0f})
      else $error("illegal common band");
   a_led_no_mid:
   assert property (LED_MODE [*3] |-> !any_mid) else $error("mid level in led mode");
   a_third_no_four:
   assert property (BIAS_THIRD [*3] |-> !any_four) else $error("level 4 with third bias");
   // main scenarios
   c_led_scan: cover property (LED_MODE && SCAN_ACTIVE && LINE_IS_COM != '0);
   c_swap_band: cover property (LINE_IS_COM[7:0] == 8'h0f);
   c_third_lcd: cover property (BIAS_THIRD && !LED_MODE && SCAN_ACTIVE);
endmodule : lsd_checker

bind lsd_display_driver lsd_checker u_chk (.REF_CLK, .NRST, .REG_ADDR, .REG_WDATA, .REG_WR,
   .LINE_LEVEL, .LINE_OE, .LINE_IS_COM, .LCD_VOLTAGE_TRIM, .BIAS_THIRD, .LED_MODE,
   .SCAN_ACTIVE);

// [verif/lsd_lf_osc_model.sv]
`timescale 1ns/100ps
module lsd_lf_osc_model (
   // reference clock
   input wire logic clk,
   // oscillator pins and rising edge counts
   output logic rc_osc,
   output logic xtal,
   output int n_rc,
   output int n_xtal
);
   // ----
   // free-running sources, sped up to keep runs short
   // ----
   // rc source, period of 8 reference cycles
   initial begin
      rc_osc = 1'b0;
      n_rc = 0;
      forever begin
         repeat (4) @(posedge clk);
         rc_osc <= ~rc_osc;
         if (!rc_osc) n_rc <= n_rc + 1;
      end
   end
   // crystal source, period of 12 reference cycles
   initial begin
      xtal = 1'b0;
      n_xtal = 0;
      forever begin
         repeat (6) @(posedge clk);
         xtal <= ~xtal;
         if (!xtal) n_xtal <= n_xtal + 1;
      end
   end
endmodule : lsd_lf_osc_model

// [verif/lsd_display_driver_tb_top.sv]
`timescale 1ns/100ps
module lsd_display_driver_tb_top;
   import lsd_pkg::*;
   logic REF_CLK, NRST, REG_WR, REG_RD, LOW_FREQ_RC_OSCILLATOR, XTAL_CLK_PIN;
   logic [ADDR_W-1:0] REG_ADDR;
   logic [DATA_W-1:0] REG_WDATA, REG_RDATA;
   logic [NUM_LINES-1:0][LVL_W-1:0] LINE_LEVEL;
   logic [NUM_LINES-1:0] LINE_OE, LINE_IS_COM;
   logic [3:0] LCD_VOLTAGE_TRIM;
   logic BIAS_THIRD, LED_MODE, SCAN_ACTIVE;
   int n_rc, n_xtal;
   int n_errors = 0;
   int num_checks = 0;
   // ----
   // clock, design and oscillators
   // ----
   initial begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end
   lsd_display_driver DUT (.REF_CLK, .NRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
      .REG_RDATA, .LOW_FREQ_RC_OSCILLATOR, .XTAL_CLK_PIN, .LINE_LEVEL, .LINE_OE, .LINE_IS_COM,
      .LCD_VOLTAGE_TRIM, .BIAS_THIRD, .LED_MODE, .SCAN_ACTIVE);
   lsd_lf_osc_model u_osc (.clk(REF_CLK), .rc_osc(LOW_FREQ_RC_OSCILLATOR),
      .xtal(XTAL_CLK_PIN), .n_rc, .n_xtal);
   // ----
   // helpers
   // ----
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // drive one bus cycle, return just after the taking edge
   task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
      REG_WR <= w;
      REG_RD <= r;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge REF_CLK);
      #1;
   endtask : bus
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
      bus(1'b0, 1'b0, a, 8'h00);
   endtask : wr
   // data stands one cycle only, then zero
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      bus(1'b0, 1'b1, a, 8'h00);
      chk("read", REG_RDATA, exp);
      bus(1'b0, 1'b0, a, 8'h00);
      chk("read after", REG_RDATA, 8'h00);
   endtask : rd
   // selected common: lcd level 0 or 4, led level 4
   function automatic int sel_of(input logic led);
      sel_of = -1;
      for (int i = 0; i < 8; i++)
         if (LINE_IS_COM[i] && (LINE_LEVEL[i] == LVL_TOP4 || (!led && LINE_LEVEL[i] == LVL_GND)))
            sel_of = i;
   endfunction : sel_of
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   // ----
   // scenarios
   // ----
   task automatic t_regs();
      rd(OFS_DRV_CTRL, RST_REG);
      rd(OFS_P0_VO, RST_REG);
      rd(OFS_P1_VO, RST_REG);
      rd(OFS_P2_VO, RST_REG);
      wr(OFS_P0_VO, 8'ha5);
      wr(OFS_P1_VO, 8'h3c);
      wr(OFS_P2_VO, 8'hf0);
      wr(OFS_DRV_CTRL, 8'h4b);
      wr(16'h0090, 8'hff);
      rd(16'h0090, 8'h00);
      rd(OFS_P2_VO, 8'hf0);
      chk("enables", LINE_OE, 28'h0f03ca5);
      chk("trim", LCD_VOLTAGE_TRIM, 4'hb);
      chk("led mode", LED_MODE, 1'b1);
      chk("scan", SCAN_ACTIVE, 1'b0);
      rd(OFS_DRV_CTRL, 8'h4b);
      $display("test regs done");
   endtask : t_regs
   // one full frame: order, band, ticks per common, segment level
   task automatic t_scan(input logic [1:0] duty, input logic swap, input logic led,
      input logic xtal);
      int ncom, first, sel, prev, t0, tk, n;
      logic [7:0] band;
      logic [LVL_W-1:0] exp;
      ncom = (duty == 2'h0) ? 8 : (duty == 2'h1) ? 6 : (duty == 2'h2) ? 5 : 4;
      first = (duty == 2'h3 && swap) ? 0 : 8 - ncom;
      band = (duty == 2'h3 && swap) ? 8'h0f : 8'hff << first;
      wr(OFS_DRV_CTRL, 8'h00);
      wr(OFS_OUT_CTRL, {6'h00, swap, 1'b0});
      wr(OFS_CLK_SEL, {7'h00, xtal});
      wr(OFS_DRV_CTRL, {1'b1, led, duty, 4'h7});
      prev = -1;
      t0 = 0;
      // one step past the frame: the first span after enable depends on the pin's phase
      for (int k = 0; k <= ncom + 1; k++) begin
         n = 0;
         while (sel_of(led) == prev && n < 4000) begin
            @(posedge REF_CLK);
            #1;
            n++;
         end
         chk("step seen", n < 4000, 1'b1);
         sel = sel_of(led);
         tk = xtal ? n_xtal : n_rc;
         if (k > 0) begin
            chk("common order", sel, first + (prev - first + 1) % ncom);
         end
         if (k > 1) begin
            chk("ticks per common", tk - t0, FRAME_TICKS / ncom);
         end
         chk("band", LINE_IS_COM, {20'h0, band});
         if ((8'h5a >> sel) & 8'h01)
            exp = led ? LVL_TOP4 : LVL_TOP4 - LINE_LEVEL[sel];
         else
            exp = led ? LVL_GND : LVL_TWO;
         chk("segment", LINE_LEVEL[27], exp);
         prev = sel;
         t0 = tk;
      end
      $display("test scan done");
   endtask : t_scan
   task automatic t_stop();
      wr(OFS_DRV_CTRL, 8'h00);
      wr(OFS_OUT_CTRL, 8'h01);
      wr(OFS_DRV_CTRL, 8'h80);
      // under one common span: common 0 selected, first frame, third bias
      repeat (300) @(posedge REF_CLK);
      #1;
      chk("scan lines", LINE_OE[27:24], 4'hf);
      chk("third sel", LINE_LEVEL[0], LVL_TOP3);
      chk("third unsel", LINE_LEVEL[1], LVL_ONE);
      chk("third seg", LINE_LEVEL[27], LVL_TWO);
      wr(OFS_DRV_CTRL, 8'h00);
      wr(OFS_STATUS, 8'hff);
      chk("stopped band", LINE_IS_COM, 28'h0);
      chk("stopped level", LINE_LEVEL[27], LVL_GND);
      rd(OFS_STATUS, 8'h00);
      $display("test stop done");
   endtask : t_stop
   // ----
   // main sequence and watchdog
   // ----
   initial begin
      NRST = 1'b0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = '0;
      REG_WDATA = '0;
      repeat (2) @(posedge REF_CLK);
      NRST <= 1'b1;
      #1;
      t_regs();
      // memory has no reset: clear it so no line level is unknown
      for (int i = 0; i < NUM_LINES - 1; i++) begin
         wr(OFS_RAM_BASE + 16'(i), 8'h00);
      end
      wr(OFS_RAM_BASE + 16'h001b, 8'h5a);
      rd(OFS_RAM_BASE + 16'h001b, 8'h5a);
      t_scan(2'h0, 1'b0, 1'b0, 1'b0);
      t_scan(2'h1, 1'b0, 1'b1, 1'b1);
      t_scan(2'h2, 1'b0, 1'b0, 1'b1);
      t_scan(2'h3, 1'b0, 1'b1, 1'b0);
      t_scan(2'h3, 1'b1, 1'b0, 1'b0);
      t_stop();
      conclude();
   end
   initial begin
      #1_200_000;
      n_errors++;
      conclude();
   end
endmodule : lsd_display_driver_tb_top
